// ===== common/spz_pkg.sv
// shared constants and types for the serial port zero block
package spz_pkg;
  localparam int SPZ_W = 8;
  localparam int SPZ_FIFO_DEPTH = 4;
  localparam int SPZ_SCK_HALF = 8;
  localparam int SPZ_CTL_W = 8;
  // port_control_register bit positions
  localparam int SPZ_PEN_BIT = 0;
  localparam int SPZ_SMODE_LO = 2;
  localparam int SPZ_SMODE_HI = 3;
  localparam int SPZ_FAULT_BIT = 5;
  localparam int SPZ_MEN_BIT = 6;
  localparam logic [7:0] SPZ_CTL_RESET = 8'h04;
  localparam logic [7:0] SPZ_CTL_WMASK = 8'h6D;
  // select_mode_field encodings
  localparam logic [1:0] SPZ_SM_3WIRE = 2'h0;
  localparam logic [1:0] SPZ_SM_4IN = 2'h1;

  typedef enum logic [0:0] {
    SPZ_IDLE = 1'b0,
    SPZ_SHIFT = 1'b1
  } spz_mstate_t;

  typedef struct packed {
    logic mosi;
    logic miso;
    logic sel;
  } spz_pin_in_t;

  typedef struct packed {
    logic mosi;
    logic mosi_oe_n;
    logic miso;
    logic miso_oe_n;
    logic sck;
    logic sck_oe_n;
    logic sel;
    logic sel_oe_n;
    logic sel_routed;
  } spz_pin_out_t;
endpackage

// ===== rtl/spz_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module spz_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } spz_sync_st_t;

  spz_sync_st_t s;
  spz_sync_st_t next_s;

  // a bit changes only once stages two and three agree
  always_comb begin
    next_s = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int i = 0; i < W; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        next_s.q[i] = s.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.q;
endmodule

// ===== rtl/spz_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module spz_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int NW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [NW-1:0] cnt;
  } spz_fifo_st_t;

  spz_fifo_st_t s;
  spz_fifo_st_t next_s;
  logic push;
  logic pop;

  assign in_ready = (s.cnt != NW'(DEPTH));
  assign out_valid = (s.cnt != '0);
  assign out_data = s.mem[s.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and count update
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + AW'(1);
    end
    if (pop) begin
      next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + AW'(1);
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + NW'(1);
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - NW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// ===== rtl/spz_port.sv
// serial port zero: master/slave spi pins, select modes and byte shifting
//
// How it works
// - master drives the master-out line; slave leaves it as input.
// - both data lines shift most significant bit first, both directions.
// - as master, master-out carries the shift register's top bit.
// - master treats master-in as input; slave drives it.
// - master-in floats when disabled or an unselected four-wire slave.
// - three-wire slave always drives master-in from its top bit.
// - master makes the serial clock; slave takes it from outside.
// - four-wire slave ignores serial clock while select input is high.
// - mode 00: three-wire, select pin unused, slave always selected.
// - mode 01: select pin is input; slave responds only when selected.
// - mode 01 master: select falling edge disables master function.
// - upper mode bit set: select pin output at lower mode bit.
// - select routed to a pin in every mode except three-wire.
// - upper mode bit is control bit 3, lower is bit 2.
// - multi-master fault clears master and port enables, sets fault.
`timescale 1ns/100ps
module spz_port
  import spz_pkg::*;
#(
  parameter int W = SPZ_W,
  parameter int HALF = SPZ_SCK_HALF,
  parameter int DEPTH = SPZ_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sck_in,
  input wire spz_pin_in_t pin_in,
  output spz_pin_out_t pin_out,
  input wire logic ctl_wr,
  input wire logic [SPZ_CTL_W-1:0] ctl_wdata,
  output logic [SPZ_CTL_W-1:0] ctl_rdata,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [W-1:0] tx_data,
  output logic rx_valid,
  output logic [W-1:0] rx_data,
  output logic busy
);
  localparam int HW = (HALF > 1) ? $clog2(HALF) : 1;
  localparam int CW = $clog2(W);

  typedef struct packed {
    logic [SPZ_CTL_W-1:0] ctl;
    spz_mstate_t ms;
    logic [HW-1:0] half;
    logic [CW-1:0] bits;
    logic sck;
    logic mbit;
    logic [W-1:0] sr;
    logic [W-1:0] hold;
    logic hold_full;
    logic done_seen;
    logic sel_last;
    logic [W-1:0] rx;
    logic rx_valid;
  } spz_main_t;

  // link-side frame state, cleared whenever the slave is not addressed
  typedef struct packed {
    logic [W-1:0] sr;
    logic [CW-1:0] cnt;
  } spz_frame_t;

  // link-side result, survives deselection
  typedef struct packed {
    logic [W-1:0] rxw;
    logic tgl;
  } spz_result_t;

  spz_main_t s;
  spz_main_t next_s;
  spz_frame_t f;
  spz_frame_t next_f;
  spz_result_t r;
  spz_result_t next_r;

  logic [1:0] smode;
  logic pen;
  logic men;
  logic master;
  logic slv_sel;
  logic slave_go;
  logic slv_rst_n;
  logic fifo_valid;
  logic fifo_pop;
  logic [W-1:0] fifo_data;
  logic [1:0] pin_q;
  logic sel_q;
  logic miso_q;
  logic tgl_q;
  logic sel_fall;
  logic last_edge;
  logic eng_run;

  assign smode = s.ctl[SPZ_SMODE_HI:SPZ_SMODE_LO];
  assign pen = s.ctl[SPZ_PEN_BIT];
  assign men = s.ctl[SPZ_MEN_BIT];
  assign master = pen && men;
  // slave addressing by select mode
  assign slv_sel = (smode == SPZ_SM_3WIRE) || ((smode == SPZ_SM_4IN) && !pin_in.sel);
  assign slave_go = pen && !men && slv_sel;
  assign slv_rst_n = rst_n && slave_go;

  // tx bytes queue ahead of the shift register
  spz_fifo #(
    .W(W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(mclk),
    .rst_n(rst_n),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // select and master-in pins into the system clock
  spz_sync #(
    .W(2)
  ) u_pin_sync (
    .clk(mclk),
    .rst_n(rst_n),
    .d({pin_in.sel, pin_in.miso}),
    .q(pin_q)
  );
  assign sel_q = pin_q[1];
  assign miso_q = pin_q[0];

  // byte-done toggle from the link clock
  spz_sync #(
    .W(1)
  ) u_done_sync (
    .clk(mclk),
    .rst_n(rst_n),
    .d(r.tgl),
    .q(tgl_q)
  );

  assign sel_fall = s.sel_last && !sel_q;
  // engine runs on only without a fault or a write that turns master off
  assign eng_run = master && !((smode == SPZ_SM_4IN) && sel_fall) &&
                   !(ctl_wr && !(ctl_wdata[SPZ_PEN_BIT] && ctl_wdata[SPZ_MEN_BIT]));
  assign last_edge = eng_run && (s.ms == SPZ_SHIFT) && s.sck &&
                     (s.half == HW'(HALF - 1)) && (s.bits == CW'(W - 1));

  // system-clock side: control, master engine, slave hand-off
  always_comb begin
    next_s = s;
    fifo_pop = 1'b0;
    next_s.rx_valid = 1'b0;
    next_s.sel_last = sel_q;
    if (ctl_wr) begin
      next_s.ctl = ctl_wdata & SPZ_CTL_WMASK;
    end
    // fault set wins over a write in the same cycle
    if (master && (smode == SPZ_SM_4IN) && sel_fall) begin
      next_s.ctl[SPZ_MEN_BIT] = 1'b0;
      next_s.ctl[SPZ_PEN_BIT] = 1'b0;
      next_s.ctl[SPZ_FAULT_BIT] = 1'b1;
      next_s.ms = SPZ_IDLE;
      next_s.sck = 1'b0;
    end else if (!eng_run) begin // a disabling write stops the engine at once
      next_s.ms = SPZ_IDLE;
      next_s.sck = 1'b0;
    end else begin
      unique case (s.ms)
        SPZ_IDLE: begin
          if (fifo_valid) begin
            fifo_pop = 1'b1;
            next_s.sr = fifo_data;
            next_s.half = '0;
            next_s.bits = '0;
            next_s.ms = SPZ_SHIFT;
          end
        end
        SPZ_SHIFT: begin
          // clock generated from the system clock by a divider
          next_s.half = s.half + HW'(1);
          if (s.half == HW'(HALF - 1)) begin
            next_s.half = '0;
            if (!s.sck) begin
              next_s.sck = 1'b1;
              next_s.mbit = miso_q;
            end else begin
              next_s.sck = 1'b0;
              next_s.sr = {s.sr[W-2:0], s.mbit};
              next_s.bits = s.bits + CW'(1);
              if (s.bits == CW'(W - 1)) begin
                next_s.rx = {s.sr[W-2:0], s.mbit};
                next_s.rx_valid = 1'b1;
                next_s.ms = SPZ_IDLE;
              end
            end
          end
        end
      endcase
    end
    // slave byte finished on the link clock
    if (tgl_q != s.done_seen) begin
      next_s.done_seen = tgl_q;
      next_s.rx = r.rxw;
      next_s.rx_valid = 1'b1;
      next_s.hold_full = 1'b0;
    end
    // slave: keep the next outgoing byte staged; staging wins over the clear
    if (pen && !men && !s.hold_full && fifo_valid) begin
      fifo_pop = 1'b1;
      next_s.hold = fifo_data;
      next_s.hold_full = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{ctl: SPZ_CTL_RESET, ms: SPZ_IDLE, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // link-clock side: slave shifter, outgoing bit from hold at byte start
  always_comb begin
    next_f = f;
    next_r = r;
    next_f.cnt = f.cnt + CW'(1);
    if (f.cnt == '0) begin
      next_f.sr = {s.hold[W-2:0], pin_in.mosi};
    end else begin
      next_f.sr = {f.sr[W-2:0], pin_in.mosi};
    end
    if (f.cnt == CW'(W - 1)) begin
      next_f.cnt = '0;
      next_r.rxw = {f.sr[W-2:0], pin_in.mosi};
      next_r.tgl = ~r.tgl;
    end
  end

  // frame state held clear while deselected, so clock edges are ignored
  always_ff @(posedge sck_in or negedge slv_rst_n) begin
    if (!slv_rst_n) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  always_ff @(posedge sck_in or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else if (slave_go) begin
      r <= next_r;
    end
  end

  // pin drivers and enables (enables low while driving)
  always_comb begin
    pin_out.mosi = s.sr[W-1];
    pin_out.mosi_oe_n = !master;
    pin_out.miso = (f.cnt == '0) ? s.hold[W-1] : f.sr[W-1];
    pin_out.miso_oe_n = !slave_go;
    pin_out.sck = s.sck;
    pin_out.sck_oe_n = !master;
    pin_out.sel = smode[0];
    pin_out.sel_oe_n = !smode[1];
    pin_out.sel_routed = (smode != SPZ_SM_3WIRE);
  end

  assign ctl_rdata = s.ctl;
  assign rx_valid = s.rx_valid;
  assign rx_data = s.rx;
  assign busy = (s.ms == SPZ_SHIFT);

  // checks on the system-clock side, the last one on the link clock
  a_mosi_dir: assert property (@(posedge mclk) disable iff (!rst_n)
    (pin_out.mosi_oe_n == !(pen && men)))
    else $error("master-out enable does not follow master mode");
  a_mosi_shift: assert property (@(posedge mclk) disable iff (!rst_n)
    (eng_run && s.ms == SPZ_SHIFT && s.sck && s.half == HW'(HALF - 1) && !last_edge) |=>
    (pin_out.mosi == $past(s.sr[W-2])))
    else $error("master-out did not advance to next lower bit");
  a_miso_input: assert property (@(posedge mclk) disable iff (!rst_n)
    master |-> pin_out.miso_oe_n)
    else $error("master-in driven while master");
  a_miso_float: assert property (@(posedge mclk) disable iff (!rst_n)
    (!pen || (smode == SPZ_SM_4IN && pin_in.sel)) |-> pin_out.miso_oe_n)
    else $error("master-in not floating when disabled or unselected");
  a_miso_3wire: assert property (@(posedge mclk) disable iff (!rst_n)
    (pen && !men && smode == SPZ_SM_3WIRE) |-> !pin_out.miso_oe_n)
    else $error("three-wire slave not driving master-in");
  a_sck_owner: assert property (@(posedge mclk) disable iff (!rst_n)
    (s.ms == SPZ_SHIFT) |-> (!pin_out.sck_oe_n && master))
    else $error("serial clock not driven during master transfer");
  a_sel_output: assert property (@(posedge mclk) disable iff (!rst_n)
    smode[1] |-> (!pin_out.sel_oe_n && pin_out.sel == ctl_rdata[SPZ_SMODE_LO]))
    else $error("select output level wrong");
  a_sel_routing: assert property (@(posedge mclk) disable iff (!rst_n)
    (pin_out.sel_routed == (ctl_rdata[SPZ_SMODE_HI:SPZ_SMODE_LO] != SPZ_SM_3WIRE)))
    else $error("select routing wrong for mode");
  a_fault_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (master && smode == SPZ_SM_4IN && sel_fall) |=>
    (ctl_rdata[SPZ_FAULT_BIT] && !ctl_rdata[SPZ_MEN_BIT] && !ctl_rdata[SPZ_PEN_BIT] && !busy))
    else $error("mode fault did not disable the port");
  a_byte_order: assert property (@(posedge mclk) disable iff (!rst_n)
    last_edge |=> (rx_valid && rx_data == {$past(s.sr[W-2:0]), $past(s.mbit)} && !busy))
    else $error("received byte not assembled msb first");
  a_sck_ignored: assert property (@(posedge sck_in) disable iff (!rst_n)
    !slave_go |-> (f.cnt == '0))
    else $error("bit counter moved while deselected");

  c_master_byte: cover property (@(posedge mclk) disable iff (!rst_n) last_edge ##1 rx_valid);
  c_slave_byte: cover property (@(posedge mclk) disable iff (!rst_n) (pen && !men) ##[1:50] rx_valid);
  c_mode_fault: cover property (@(posedge mclk) disable iff (!rst_n) master && smode == SPZ_SM_4IN && sel_fall);
endmodule

// ===== tb/spz_far_model.sv
// far-side spi device: slave answering a master port, master driving a slave port
`timescale 1ns/100ps
module spz_far_model
  import spz_pkg::*;
(
  input wire logic dut_sck,
  input wire logic dut_mosi,
  input wire logic dut_miso,
  output logic far_miso,
  output logic far_mosi,
  output logic far_sel,
  output logic far_sck,
  output logic [7:0] got
);
  logic [7:0] out_sh = 8'hA5;
  logic [7:0] in_sh = 8'h00;
  int cnt = 0;

  initial begin
    far_sck = 1'b0;
    far_sel = 1'b1;
    far_mosi = 1'b0;
    got = 8'h00;
  end

  // slave role: top bit first, reply is the inverse of the byte last taken
  assign far_miso = out_sh[7];

  // slave role: take master-out on rise
  always @(posedge dut_sck) begin
    in_sh = {in_sh[6:0], dut_mosi};
    cnt = cnt + 1;
    if (cnt == 8) got = in_sh;
  end

  // slave role: next bit on fall, reload after the eighth bit
  always @(negedge dut_sck) begin
    if (cnt == 8) begin
      out_sh = ~in_sh;
      cnt = 0;
    end else if (cnt > 0) out_sh = {out_sh[6:0], 1'b0};
  end

  // master role: select level held by the far side
  task automatic set_sel(input logic v);
    far_sel = v;
  endtask

  // master role: one byte, msb first, clock still outside the frame; sole slave on the bus
  task automatic frame(input logic [7:0] b, input logic sel_lvl, output logic [7:0] r);
    #7;
    far_sel = sel_lvl;
    #200;
    for (int i = 7; i >= 0; i--) begin
      far_mosi = b[i];
      #15;
      r[i] = dut_miso;
      far_sck = 1'b1;
      #15;
      far_sck = 1'b0;
    end
    far_mosi = ~b[0]; // released line shows no stale value
    #300;
    far_sel = 1'b1;
  endtask
endmodule

// ===== tb/spz_port_tb_top.sv
// self-checking bench for the serial port zero block
`timescale 1ns/100ps
module spz_port_tb_top;
  import spz_pkg::*;
  logic mclk, rst_n, ctl_wr, tx_valid, tx_ready, rx_valid, busy;
  logic [7:0] ctl_wdata, ctl_rdata, tx_data, rx_data, far_got, rx_last, prev, b, m, r, v;
  logic [7:0] q[4];
  logic far_miso, far_mosi, far_sel, far_sck;
  logic [31:0] t;
  logic [31:0] seed = 32'h0853615D;
  spz_pin_in_t pin_in;
  spz_pin_out_t pin_out;
  int num_errors = 0;
  int comparisons = 0;
  int rx_cnt = 0;
  int c0;

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // wire levels worked out from the port's enables alone
  assign pin_in = {pin_out.mosi_oe_n ? far_mosi : pin_out.mosi, pin_out.miso_oe_n ? far_miso : pin_out.miso,
                   pin_out.sel_oe_n ? far_sel : pin_out.sel};

  spz_port #(.HALF(5)) i_spz_port (.mclk(mclk), .rst_n(rst_n), .sck_in(far_sck), .pin_in(pin_in),
    .pin_out(pin_out), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data), .busy(busy));

  spz_far_model i_far (.dut_sck(pin_out.sck), .dut_mosi(pin_in.mosi), .dut_miso(pin_in.miso),
    .far_miso(far_miso), .far_mosi(far_mosi), .far_sel(far_sel), .far_sck(far_sck), .got(far_got));

  // received byte capture
  always @(posedge mclk) begin
    if (rx_valid === 1'b1) begin
      rx_last <= rx_data;
      rx_cnt <= rx_cnt + 1;
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // master-in driven only by an enabled, selected slave
  function automatic logic exp_miso_oe_n(input logic ms, input logic [1:0] md, input logic s);
    return !(!ms && (md == 2'h0 || (md == 2'h1 && !s)));
  endfunction

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chkb(input string what, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic wait_clk(input int k);
    repeat (k) @(posedge mclk);
    #2;
  endtask

  task automatic wr_ctl(input logic [7:0] d);
    ctl_wdata = d;
    ctl_wr = 1'b1;
    wait_clk(1);
    ctl_wr = 1'b0;
  endtask

  task automatic push(input logic [7:0] d);
    tx_data = d;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1) wait_clk(1);
    wait_clk(1);
    tx_valid = 1'b0;
    wait_clk(1);
  endtask

  task automatic wait_rx(input int c);
    for (int k = 0; k < 400 && rx_cnt == c; k++) wait_clk(1);
    chkb("rx pulse", 1'b1, rx_cnt != c);
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog
  initial begin
    #500000;
    num_errors++;
    end_of_test();
  end

  initial begin
    rst_n = 1'b0;
    ctl_wr = 1'b0;
    ctl_wdata = 8'h00;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    prev = 8'h5A;
    repeat (16) @(posedge mclk);
    #2;
    rst_n = 1'b1;
    wait_clk(1);
    chk("ctl reset", 8'h04, ctl_rdata);
    chkb("miso idle", 1'b1, pin_out.miso_oe_n);
    // pin directions for master and slave in every select mode
    for (int i = 0; i < 8; i++) begin
      i_far.set_sel(1'b1);
      v = 8'h01 | {1'b0, i[2], 4'h0, 2'h0} | {4'h0, i[1:0], 2'h0};
      wr_ctl(v);
      t = rnd();
      if (!i[2]) i_far.set_sel(t[0]);
      wait_clk(6);
      chk("ctl read", v, ctl_rdata);
      chkb("mosi oe", !i[2], pin_out.mosi_oe_n);
      chkb("sck oe", !i[2], pin_out.sck_oe_n);
      chkb("miso oe", exp_miso_oe_n(i[2], i[1:0], far_sel), pin_out.miso_oe_n);
      chkb("sel oe", !i[1], pin_out.sel_oe_n);
      if (i[1]) chkb("sel level", i[0], pin_out.sel);
      chkb("sel routed", i[1:0] != 2'h0, pin_out.sel_routed);
    end
    // fill the buffer while disabled, then drain as master
    for (int k = 0; k < 2; k++) begin
      wr_ctl(k ? 8'h48 : 8'h40);
      for (int j = 0; j < 4; j++) begin
        t = rnd();
        q[j] = t[7:0];
        push(q[j]);
      end
      chkb("tx full", 1'b0, tx_ready);
      wr_ctl(k ? 8'h49 : 8'h41);
      for (int j = 0; j < 4; j++) begin
        c0 = rx_cnt;
        for (int n = 0; n < 20 && busy !== 1'b1; n++) wait_clk(1);
        chkb("mosi msb", q[j][7], pin_out.mosi);
        wait_rx(c0);
        chk("master rx", ~prev, rx_last);
        chk("far rx", q[j], far_got);
        prev = q[j];
      end
    end
    // slave bytes in three-wire and four-wire modes, with ignored deselected frames
    for (int k = 0; k < 4; k++) begin
      i_far.set_sel(1'b1);
      wr_ctl(k[0] ? 8'h05 : 8'h01);
      t = rnd();
      b = t[7:0];
      m = t[15:8];
      push(b);
      wait_clk(8);
      if (k[0]) begin
        c0 = rx_cnt;
        i_far.frame(~m, 1'b1, r);
        wait_clk(10);
        chkb("ignored frame", 1'b1, rx_cnt == c0);
      end
      c0 = rx_cnt;
      i_far.frame(m, 1'b0, r);
      wait_rx(c0);
      chk("slave rx", m, rx_last);
      chk("slave tx", b, r);
    end
    // select falling edge in multi-master mode
    i_far.set_sel(1'b1);
    wr_ctl(8'h45);
    wait_clk(6);
    i_far.set_sel(1'b0);
    wait_clk(10);
    chk("fault ctl", 8'h24, ctl_rdata);
    chkb("fault sck", 1'b1, pin_out.sck_oe_n);
    chkb("fault mosi", 1'b1, pin_out.mosi_oe_n);
    // software clears the fault and leaves the port disabled
    wr_ctl(8'h00);
    chk("fault clear", 8'h00, ctl_rdata);
    end_of_test();
  end
endmodule
